// ### pkg/rgb_pwm_pkg.sv
// Package: constants, register map and state types for the RGB channel PWM dimmer
`default_nettype none
package rgb_pwm_pkg;
	// Clock and PWM timing
	localparam int unsigned CLK_HZ                = 250_000_000;
	localparam int unsigned PWM_FREQ_HZ           = 29_000;
	localparam int unsigned PERIOD_STEPS          = 512;
	localparam int unsigned STEP_DIV              = (CLK_HZ + PWM_FREQ_HZ * PERIOD_STEPS / 2)
	                                                / (PWM_FREQ_HZ * PERIOD_STEPS);
	localparam int unsigned SLEEP_DEGLITCH_MS     = 30;
	localparam int unsigned SLEEP_DEGLITCH_CYCLES = SLEEP_DEGLITCH_MS * (CLK_HZ / 1000);

	// Sizes
	localparam int unsigned MAX_MODULES   = 12;
	localparam int unsigned CH_PER_MODULE = 3;
	localparam int unsigned MAX_CHANNELS  = MAX_MODULES * CH_PER_MODULE;
	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned DIV_W         = 5;
	localparam int unsigned IDLE_W        = 24;
	localparam int unsigned LOG_SHIFT     = 5;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL        = 12'h000;
	localparam logic [11:0] OFF_STATUS      = 12'h004;
	localparam logic [11:0] OFF_COLOR_BASE  = 12'h100;
	localparam logic [11:0] OFF_INTENS_BASE = 12'h200;

	// Fixed points of the period, in steps
	localparam logic [9:0] PHASE_CENTRE = 10'h100;
	localparam logic [9:0] PERIOD_FULL  = 10'h200;
	localparam logic [8:0] STEP_LAST    = 9'h1FF;

	// Reset value, and the end levels of the log curve
	localparam logic [7:0] INTENS_RESET = 8'hFF;
	localparam logic [7:0] LEVEL_ZERO   = 8'h00;
	localparam logic [7:0] LEVEL_FULL   = 8'hFF;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	// Control register, bit 3 down to bit 0
	typedef struct packed {
		logic dither_en;
		logic log_en;
		logic sleep_en;
		logic run;
	} ctrl_t;

	typedef enum logic {PWR_ACTIVE, PWR_SLEEP} pwr_t;

	typedef struct packed {
		ctrl_t                                ctrl;
		pwr_t                                 pwr;
		logic [MAX_CHANNELS-1:0][7:0]         color;
		logic [MAX_MODULES-1:0][7:0]          intens;
		logic [MAX_CHANNELS-1:0][9:0]         width;
		logic [8:0]                           step;
		logic [2:0]                           frame;
		logic [DIV_W-1:0]                     div;
		logic [IDLE_W-1:0]                    idle;
		logic [MAX_CHANNELS-1:0]              sink;
		apb_rsp_t                             rsp;
	} state_t;

	localparam ctrl_t CTRL_RESET = '{dither_en: 1'b1, log_en: 1'b1, sleep_en: 1'b1, run: 1'b0};

	localparam state_t STATE_RESET = '{
		ctrl:    CTRL_RESET,
		pwr:     PWR_ACTIVE,
		intens:  {MAX_MODULES{INTENS_RESET}},
		default: '0
	};
endpackage : rgb_pwm_pkg
`default_nettype wire

// ### design/rgb_channel_pwm_dimmer.sv
// Design: per-channel colour times intensity PWM with dithering, phase groups and power save
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Each channel owns an 8-bit colour value, independent of every other channel.
// - Channels 3m, 3m+1 and 3m+2 share intensity register of module m.
// - Module intensity offers 256 steps, independent of the colour values.
// - Intensity resets to FFh, which means a full intensity factor.
// - One control bit picks log or linear intensity; curve never touches colour.
// - Duty equals colour value times the scaled module intensity.
// - Duty has 12 bits: 9-bit counter compare plus 3-bit dither fraction.
// - Per eight periods, fraction-many pulses are one step longer.
// - Dither enable resets set; when clear fraction is ignored, 9-bit duty.
// - The period repeats at about 29 kHz, above hearing.
// - Modules with index mod 3 zero: fixed pulse start, end moves.
// - Modules with index mod 3 one: pulse centred, widens both ways.
// - Modules with index mod 3 two: fixed pulse end, start moves.
// - Sleep needs run set, sleep enable set, all outputs off past deglitch time.
// - Any bus command while asleep wakes at once; registers are kept.
// - Sleep enable resets to one.
// - Run clear holds all sinks off; registers stay readable and writable.
module rgb_channel_pwm_dimmer #(
	parameter int unsigned num_modules           = rgb_pwm_pkg::MAX_MODULES,
	parameter int unsigned sleep_deglitch_cycles = rgb_pwm_pkg::SLEEP_DEGLITCH_CYCLES
) (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire rgb_pwm_pkg::apb_req_t                  apb_req,
	output wire rgb_pwm_pkg::apb_rsp_t                  apb_rsp,
	output wire logic [rgb_pwm_pkg::MAX_CHANNELS-1:0]   sink_output
);
	import rgb_pwm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Piecewise exponential curve: 3-bit octave, 5-bit mantissa
	function automatic logic [7:0] log_curve(input logic [7:0] level);
		logic [12:0] shifted;
		shifted = 13'({1'b1, level[4:0]}) << level[7:5];
		if (level == LEVEL_ZERO) begin
			log_curve = LEVEL_ZERO;
		end else if (level == LEVEL_FULL) begin
			log_curve = LEVEL_FULL;
		end else begin
			log_curve = shifted[LOG_SHIFT+7:LOG_SHIFT];
		end
	endfunction : log_curve

	// Word address match of the idx-th register in a bank
	function automatic logic reg_hit(
		input logic [11:0] addr,
		input logic [11:0] base,
		input int unsigned idx
	);
		reg_hit = (addr == 12'(32'(base) + (idx << 2)));
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////
	// State

	localparam int unsigned   LIVE_CHANNELS = num_modules * CH_PER_MODULE;
	localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(sleep_deglitch_cycles);
	localparam logic [DIV_W-1:0]  DIV_LAST   = DIV_W'(STEP_DIV - 1);

	state_t                         cur;
	state_t                         next_state;
	logic [MAX_CHANNELS-1:0][9:0]   new_width;
	logic [MAX_CHANNELS-1:0]        pulse_on;
	logic [2:0]                     frame_rev;

	// Outputs straight from the state register
	assign apb_rsp     = cur.rsp;
	assign sink_output = cur.sink;

	// Bit-reversed frame spreads stretched pulses over the eight periods
	assign frame_rev = {cur.frame[0], cur.frame[1], cur.frame[2]};

	////////////////////////////////////////////////////////////////////////////
	// Per-channel duty and phase compare

	for (genvar ch = 0; ch < MAX_CHANNELS; ch++) begin : g_chan
		localparam int unsigned MOD   = ch / CH_PER_MODULE;
		localparam int unsigned PHASE = MOD % CH_PER_MODULE;
		localparam logic        LIVE  = (ch < LIVE_CHANNELS);

		logic [7:0]  scale;
		logic [15:0] product;
		logic [11:0] duty;
		logic        stretch;
		logic [9:0]  w;
		logic [9:0]  start;
		logic [9:0]  stop;
		logic [9:0]  pos;

		// Curve acts on intensity only, never on colour
		assign scale = cur.ctrl.log_en ? log_curve(cur.intens[MOD]) : cur.intens[MOD];
		assign product = 16'(cur.color[ch]) * 16'(scale);
		// Top twelve bits: nine for the counter, three for dither
		assign duty = product[15:4];
		assign stretch = cur.ctrl.dither_en && (frame_rev < duty[2:0]);
		assign new_width[ch] = LIVE ? (10'(duty[11:3]) + 10'(stretch)) : 10'h000;

		// Pulse window from the width latched at the boundary
		assign w   = cur.width[ch];
		assign pos = 10'(cur.step);
		if (PHASE == 0) begin : g_p1
			assign start = 10'h000;
		end else if (PHASE == 1) begin : g_p2
			assign start = PHASE_CENTRE - (w >> 1);
		end else begin : g_p3
			assign start = PERIOD_FULL - w;
		end
		assign stop = start + w;
		assign pulse_on[ch] = (pos >= start) && (pos < stop);
	end : g_chan

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic access;
		logic hit;
		logic wr_ok;
		logic rd_only;
		logic tick;
		logic boundary;
		logic [31:0] rdata;
		access   = 1'b0;
		hit      = 1'b0;
		wr_ok    = 1'b0;
		rd_only  = 1'b0;
		tick     = 1'b0;
		boundary = 1'b0;
		rdata    = 32'h0000_0000;
		next_state = cur;

		// Step divider; rounded to the nearest rate, so period is near 29 kHz
		tick = (cur.div == DIV_LAST);
		if (tick) begin
			next_state.div = '0;
			next_state.step = cur.step + 9'h001;
		end else begin
			next_state.div = cur.div + DIV_W'(1);
		end
		boundary = tick && (cur.step == STEP_LAST);

		// Widths only change between periods, so no pulse is cut short
		if (boundary) begin
			next_state.width = new_width;
			next_state.frame = cur.frame + 3'h1;
		end

		// Sinks gated by run and by sleep; one cycle behind the compare
		if (cur.ctrl.run && (cur.pwr == PWR_ACTIVE)) begin
			next_state.sink = pulse_on;
		end else begin
			next_state.sink = '0;
		end

		// Address decode, shared by the read and write paths
		access = apb_req.psel && apb_req.penable;
		if (apb_req.paddr == OFF_CTRL) begin
			hit = 1'b1;
			wr_ok = 1'b1;
			rdata = 32'(cur.ctrl);
		end
		if (apb_req.paddr == OFF_STATUS) begin
			hit = 1'b1;
			rd_only = 1'b1;
			rdata = {16'h0000, 7'(cur.step), cur.frame, 3'h0,
			         |cur.sink, cur.ctrl.run, (cur.pwr == PWR_SLEEP)};
		end
		for (int ch = 0; ch < MAX_CHANNELS; ch++) begin
			if ((ch < LIVE_CHANNELS) && reg_hit(apb_req.paddr, OFF_COLOR_BASE, ch)) begin
				hit = 1'b1;
				wr_ok = 1'b1;
				rdata = 32'(cur.color[ch]);
			end
		end
		for (int m = 0; m < MAX_MODULES; m++) begin
			if ((m < num_modules) && reg_hit(apb_req.paddr, OFF_INTENS_BASE, m)) begin
				hit = 1'b1;
				wr_ok = 1'b1;
				rdata = 32'(cur.intens[m]);
			end
		end

		// One wait state: pready rises in the second access cycle
		next_state.rsp.pready = access && !cur.rsp.pready;
		if (access && !cur.rsp.pready) begin
			next_state.rsp.pslverr = !hit || (apb_req.pwrite && rd_only);
			next_state.rsp.prdata = (apb_req.pwrite || !hit) ? 32'h0000_0000 : rdata;
		end else begin
			next_state.rsp.pslverr = 1'b0;
			next_state.rsp.prdata = 32'h0000_0000;
		end

		// Writes land on the completing edge only
		if (access && cur.rsp.pready && apb_req.pwrite && wr_ok) begin
			if (apb_req.paddr == OFF_CTRL) begin
				next_state.ctrl = ctrl_t'(apb_req.pwdata[3:0]);
			end
			for (int ch = 0; ch < MAX_CHANNELS; ch++) begin
				if (reg_hit(apb_req.paddr, OFF_COLOR_BASE, ch)) begin
					next_state.color[ch] = apb_req.pwdata[7:0];
				end
			end
			for (int m = 0; m < MAX_MODULES; m++) begin
				if (reg_hit(apb_req.paddr, OFF_INTENS_BASE, m)) begin
					next_state.intens[m] = apb_req.pwdata[7:0];
				end
			end
		end

		// Deglitch: count cycles of all sinks off while sleep is allowed
		if (!cur.ctrl.run || !cur.ctrl.sleep_en || (cur.sink != '0)) begin
			next_state.idle = '0;
		end else if (cur.idle != IDLE_LIMIT) begin
			next_state.idle = cur.idle + IDLE_W'(1);
		end

		// Power state; registers are never touched here
		unique case (cur.pwr)
			PWR_ACTIVE: begin
				if (cur.idle == IDLE_LIMIT) begin
					next_state.pwr = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				// Any bus request wakes, even one to an unmapped address
				if (apb_req.psel) begin
					next_state.pwr = PWR_ACTIVE;
					next_state.idle = '0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	// Reset loads constants only; intensities come up at full scale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= STATE_RESET;
		end else begin
			cur <= next_state;
		end
	end

endmodule : rgb_channel_pwm_dimmer
`default_nettype wire

// ### verification/rgb_pwm_checker.sv
// Checker: APB handshake and sink output relations at the dimmer ports
`default_nettype none
module rgb_pwm_checker #(
	parameter int unsigned num_modules = 12
) (
	input wire logic                                 pclk,
	input wire logic                                 presetn,
	input wire rgb_pwm_pkg::apb_req_t                apb_req,
	input wire rgb_pwm_pkg::apb_rsp_t                apb_rsp,
	input wire logic [rgb_pwm_pkg::MAX_CHANNELS-1:0] sink_output
);
	import rgb_pwm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase still waiting for its single wait state
	wire logic acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;

	////////////////////////////////////////////////////////////////////////////
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
	a_ready_after: assert property (acc |=> apb_rsp.pready) else $error("pready late");
	a_ready_cause: assert property (apb_rsp.pready |-> $past(acc)) else $error("pready uncaused");
	a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("pready outside access");
	a_idle_quiet: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0 && !apb_rsp.pslverr)
		else $error("response not idle");
	a_write_data: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == '0)
		else $error("write returned data");
	a_unused_sinks: assert property ((sink_output >> (3 * num_modules)) == '0)
		else $error("absent sink driven");
	a_reset_quiet: assert property ($rose(presetn) |-> !apb_rsp.pready && sink_output == '0)
		else $error("outputs active after reset");

	// Main scenarios reached
	c_error: cover property (apb_rsp.pready && apb_rsp.pslverr);
	c_read: cover property (apb_rsp.pready && !apb_req.pwrite);
	c_sink: cover property ($rose(sink_output[0]));
endmodule : rgb_pwm_checker
`default_nettype wire

// ### verification/led_sink_model.sv
// Partner: LED modules on the sinks, logging pulse start and length
`default_nettype none
module led_sink_model #(
	parameter int n = 36
) (
	input wire logic         pclk,
	input wire logic [n-1:0] sink_output
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned  cyc = 0;
	int unsigned  rise [n];
	int unsigned  width [n];
	logic [n-1:0] last = '0;
	// Lengths in cycles, so a one-cycle output lag cancels out
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		last <= sink_output;
		for (int i = 0; i < n; i++) begin
			if (sink_output[i] && !last[i])
				rise[i] <= cyc;
			if (!sink_output[i] && last[i])
				width[i] <= cyc - rise[i];
		end
	end
endmodule : led_sink_model
`default_nettype wire

// ### verification/tb.sv
// Testbench: registers, phase groups, dithering and stop of the dimmer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rgb_pwm_pkg::*;
	localparam int unsigned  PER = PERIOD_STEPS * STEP_DIV;
	logic                    pclk = 1'b0;
	logic                    presetn = 1'b0;
	apb_req_t                apb_req = '0;
	apb_rsp_t                apb_rsp;
	logic [MAX_CHANNELS-1:0] sink_output;
	logic [31:0]             rd;
	logic                    err;
	int                      mismatches = 0;
	int                      compares = 0;
	int unsigned             longs = 0;
	int unsigned             r0;

	always #2 pclk = ~pclk;

	rgb_channel_pwm_dimmer #(.num_modules(10), .sleep_deglitch_cycles(50)) i_dut (.pclk(pclk),
		.presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sink_output(sink_output));
	led_sink_model #(.n(MAX_CHANNELS)) i_led (.pclk(pclk), .sink_output(sink_output));

	////////////////////////////////////////////////////////////////////////////
	// One APB transfer; an idle cycle after it keeps drives one per step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		if (n >= 20)
			mismatches++;
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge pclk);
	endtask : xfer

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		xfer(1'b0, a, '0);
		chk(rd, e);
		chk({31'b0, err}, {31'b0, ee});
	endtask : rdk

	task automatic conclude();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////
	// Watchdog sized 3000 cycles beyond the eleven periods of the whole sequence
	initial begin
		repeat (11 * PER + 3000) @(posedge pclk);
		mismatches++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdk(OFF_CTRL, 32'h0000000E, 1'b0);
		rdk(OFF_INTENS_BASE, 32'h000000FF, 1'b0);
		rdk(OFF_COLOR_BASE + 12'h078, '0, 1'b1);
		rdk(12'h300, '0, 1'b1);
		xfer(1'b1, OFF_STATUS, 32'h00000001);
		chk({31'b0, err}, 32'h00000001);
		// All colours still zero, so run with sleep allowed dozes off after the deglitch count
		xfer(1'b1, OFF_CTRL, 32'h00000003);
		repeat (60) @(posedge pclk);
		chk({31'b0, i_dut.cur.pwr == PWR_SLEEP}, 32'h00000001);
		rdk(OFF_CTRL, 32'h00000003, 1'b0);
		chk({31'b0, i_dut.cur.pwr == PWR_ACTIVE}, 32'h00000001);
		for (int c = 0; c < 9; c += 3)
			xfer(1'b1, OFF_COLOR_BASE + 12'(4 * c), 32'h00000080);
		xfer(1'b1, OFF_COLOR_BASE + 12'h004, 32'h00000081);
		xfer(1'b1, OFF_CTRL, 32'h00000009);
		repeat (PER) @(posedge pclk);
		// Eight periods: fraction seven stretches seven pulses
		for (int i = 0; i < 8; i++) begin
			repeat (PER) @(posedge pclk);
			longs += (i_led.width[1] == 257 * STEP_DIV);
			if (i == 0) begin
				r0 = i_led.rise[0];
				chk(i_led.width[0], 255 * STEP_DIV);
				chk(i_led.width[6], 255 * STEP_DIV);
				chk((i_led.rise[3] - r0 + PER) % PER, 129 * STEP_DIV);
				chk((i_led.rise[6] - r0 + PER) % PER, 257 * STEP_DIV);
			end
			if (i == 1)
				chk(i_led.rise[0] - r0, PER);
		end
		chk(longs, 7);
		// Module two dimmed on the log curve; full scale stays full, so other modules keep their widths
		xfer(1'b1, OFF_INTENS_BASE + 12'h008, 32'h00000020);
		xfer(1'b1, OFF_CTRL, 32'h00000005);
		repeat (2 * PER) @(posedge pclk);
		chk(i_led.width[1], 256 * STEP_DIV);
		chk(i_led.width[6], 2 * STEP_DIV);
		chk(i_led.width[3], 255 * STEP_DIV);
		xfer(1'b1, OFF_CTRL, 32'h00000000);
		repeat (3) @(posedge pclk);
		chk({31'b0, |sink_output}, '0);
		rdk(OFF_COLOR_BASE + 12'h00C, 32'h00000080, 1'b0);
		xfer(1'b1, OFF_COLOR_BASE + 12'h00C, 32'h00000040);
		rdk(OFF_COLOR_BASE + 12'h00C, 32'h00000040, 1'b0);
		conclude();
	end
endmodule : tb

bind rgb_channel_pwm_dimmer rgb_pwm_checker #(.num_modules(num_modules)) i_chk (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sink_output(sink_output));
`default_nettype wire
